// file: hw/pvc_pkg.sv
// process value conditioning: shared types and constants
// assumes one 200 MHz clock; all settings arrive as plain ports in engineering units
//
// What this block does
// - voltage input: full span maps to scale_high, zero span to scale_low.
// - thermocouple and RTD: no scale mapping; scale settings reported hidden.
// - first-order lag input filter, off or 1 to 120; larger is slower.
// - separate display filter acts only on the displayed value, never control.
// - sensor break forces value to 105% of span (up) or -5% (down).
// - burn-out detection only for thermocouple and RTD, never voltage.
// - on burn-out, substituted value feeds outputs and preset output is requested.
// - burn-out select off: no detection, filtered value passes through unchanged, no preset request.
// - thermocouple adds junction temperature when compensation on, else passes through.
// - junction sensing error: alternate error with value, compensate with zero.
// - whole-range bias of -100% to +100% of span added to value.
// - three ordered breakpoints with five bias values for piecewise correction.
// - segment value = burn-out stage value + start bias + interpolated bias difference.
// - internal value clamped to -5% and 105% of span.
// - over-range flag above 105%, under-range flag below -5%.
// - input type change pulses settings_reinit for one clock; the range and scale ports are not reset here.
// - range_high and range_low are the 100% and 0% span endpoints.
package pvc_pkg;

    localparam int VW      = 24;
    localparam int DW      = 48;
    typedef logic signed [VW-1:0] pvc_val_t;
    typedef logic signed [DW-1:0] pvc_wide_t;

    // input kinds
    typedef enum logic [1:0] {
        PVC_IN_TC   = 2'b00,
        PVC_IN_RTD  = 2'b01,
        PVC_IN_VOLT = 2'b10
    } pvc_in_t;

    // burn-out selection
    typedef enum logic [1:0] {
        PVC_BO_OFF  = 2'b00,
        PVC_BO_UP   = 2'b01,
        PVC_BO_DOWN = 2'b10
    } pvc_bo_t;

    // voltage samples are a fraction of span, 2^16 = 100 %
    localparam int        FRAC_SH   = 16;
    // 5 % of span is span / 20
    localparam pvc_val_t  PCT5_DIV  = 24'sh000014;
    localparam logic [6:0] FILT_OFF = 7'h00;
    localparam pvc_val_t  VAL_ZERO  = 24'sh000000;
    localparam logic [5:0] DIV_STEPS = 6'h30;

    // junction error display alternation
    localparam int CLK_KHZ     = 200000;
    localparam int ALT_TIME_MS = 500;
    localparam int ALT_CYCLES  = ALT_TIME_MS * CLK_KHZ;
    localparam int ALT_W       = 27;

endpackage : pvc_pkg

// file: hw/pvc_div.sv
// sequential signed divider, one quotient bit per clock
// assumes start only while idle; zero divisor gives an undefined quotient
`timescale 1ns/1ps
`default_nettype none
module pvc_div (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // request
    input  wire logic              start,
    input  wire pvc_pkg::pvc_wide_t dividend,
    input  wire pvc_pkg::pvc_val_t  divisor,
    // answer
    output logic                   done,
    output pvc_pkg::pvc_wide_t      quotient
);
    logic [47:0] num_reg;
    logic [23:0] den_reg;
    logic [23:0] rem_reg;
    logic [5:0]  cnt_reg;
    logic        busy_reg;
    logic        neg_reg;
    logic [24:0] shifted;
    logic [24:0] trial;
    logic [47:0] num_next;

    assign shifted  = {rem_reg, num_reg[47]};
    assign trial    = shifted - {1'b0, den_reg};
    assign num_next = {num_reg[46:0], ~trial[24]};

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            num_reg  <= '0;
            den_reg  <= '0;
            rem_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            neg_reg  <= 1'b0;
        end
        else if (start)
        begin
            num_reg  <= dividend[47] ? 48'(-dividend) : 48'(dividend);
            den_reg  <= divisor[23] ? 24'(-divisor) : 24'(divisor);
            rem_reg  <= '0;
            cnt_reg  <= pvc_pkg::DIV_STEPS;
            busy_reg <= 1'b1;
            neg_reg  <= dividend[47] ^ divisor[23];
        end
        else if (busy_reg)
        begin
            num_reg  <= num_next;
            rem_reg  <= trial[24] ? shifted[23:0] : trial[23:0];
            cnt_reg  <= cnt_reg - 6'h01;
            busy_reg <= (cnt_reg != 6'h01);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done     <= 1'b0;
            quotient <= '0;
        end
        else
        begin
            done <= busy_reg && (cnt_reg == 6'h01);
            if (busy_reg && (cnt_reg == 6'h01))
                quotient <= neg_reg ? -$signed(num_next) : $signed(num_next);
        end
    end
endmodule : pvc_div
`default_nettype wire

// file: hw/pvc_top.sv
// process value conditioning pipeline, one sample at a time
// assumes settings are stable while a sample is processed; one shared divider
`timescale 1ns/1ps
`default_nettype none
module pvc_top #(
    parameter int ALT_CYCLES = pvc_pkg::ALT_CYCLES
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // sensor front end
    input  wire logic              sample_valid,
    input  wire pvc_pkg::pvc_val_t  raw_value,
    input  wire logic              sensor_break,
    input  wire pvc_pkg::pvc_val_t  junction_temp,
    input  wire logic              junction_error,
    // settings
    input  wire pvc_pkg::pvc_in_t   input_type,
    input  wire pvc_pkg::pvc_val_t  range_high,
    input  wire pvc_pkg::pvc_val_t  range_low,
    input  wire pvc_pkg::pvc_val_t  scale_high,
    input  wire pvc_pkg::pvc_val_t  scale_low,
    input  wire logic [6:0]        input_filter_time,
    input  wire logic [6:0]        display_filter_time,
    input  wire pvc_pkg::pvc_bo_t   burnout_select,
    input  wire logic              junction_comp_select,
    input  wire pvc_pkg::pvc_val_t  global_bias,
    input  wire pvc_pkg::pvc_val_t  bias_breakpoint_1,
    input  wire pvc_pkg::pvc_val_t  bias_breakpoint_2,
    input  wire pvc_pkg::pvc_val_t  bias_breakpoint_3,
    input  wire pvc_pkg::pvc_val_t  bias_at_low,
    input  wire pvc_pkg::pvc_val_t  bias_at_point_1,
    input  wire pvc_pkg::pvc_val_t  bias_at_point_2,
    input  wire pvc_pkg::pvc_val_t  bias_at_point_3,
    input  wire pvc_pkg::pvc_val_t  bias_at_high,
    // conditioned results
    output logic                   pv_valid,
    output pvc_pkg::pvc_val_t       pv_control,
    output pvc_pkg::pvc_val_t       pv_display,
    output logic                   over_range_flag,
    output logic                   under_range_flag,
    output logic                   preset_request,
    // setting management and display status
    output logic                   scale_settings_visible,
    output logic                   settings_reinit,
    output logic                   junction_alarm_phase
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_SCALE = 3'b001,
        S_FILT  = 3'b010,
        S_BURN  = 3'b011,
        S_BIAS  = 3'b100,
        S_LIMIT = 3'b101,
        S_DISP  = 3'b110,
        S_OUT   = 3'b111
    } pvc_state_t;

    pvc_state_t        state;
    pvc_pkg::pvc_val_t raw_reg;
    pvc_pkg::pvc_in_t  typ_reg;
    pvc_pkg::pvc_in_t  typ_prev_reg;
    logic              brk_reg;
    logic              jerr_reg;
    pvc_pkg::pvc_val_t stage1_reg;
    pvc_pkg::pvc_val_t filt_reg;
    pvc_pkg::pvc_val_t burn_reg;
    pvc_pkg::pvc_val_t corr_reg;
    pvc_pkg::pvc_val_t lim_reg;
    pvc_pkg::pvc_val_t disp_reg;
    logic              over_reg;
    logic              under_reg;
    logic              preset_reg;
    logic              fprim_reg;
    logic              dprim_reg;
    logic              wait_reg;
    logic [pvc_pkg::ALT_W-1:0] alt_cnt_reg;
    logic              alt_phase_reg;

    pvc_pkg::pvc_val_t  span;
    pvc_pkg::pvc_val_t  pct5;
    pvc_pkg::pvc_val_t  hi_lim;
    pvc_pkg::pvc_val_t  lo_lim;
    pvc_pkg::pvc_val_t  stage1_c;
    pvc_pkg::pvc_wide_t scale_prod;
    pvc_pkg::pvc_val_t  burn_c;
    pvc_pkg::pvc_val_t  seg_s;
    pvc_pkg::pvc_val_t  seg_e;
    pvc_pkg::pvc_val_t  seg_b0;
    pvc_pkg::pvc_val_t  seg_b1;
    pvc_pkg::pvc_val_t  base_c;
    logic               div_need;
    logic               div_start;
    logic               div_done;
    pvc_pkg::pvc_wide_t div_num;
    pvc_pkg::pvc_val_t  div_den;
    pvc_pkg::pvc_wide_t div_q;

    // ----------------------------------------
    // span and limits
    // ----------------------------------------
    assign span   = range_high - range_low;
    assign pct5   = span / pvc_pkg::PCT5_DIV;
    assign hi_lim = range_high + pct5;
    assign lo_lim = range_low - pct5;

    // ----------------------------------------
    // scaling and compensation
    // ----------------------------------------
    assign scale_prod = pvc_pkg::pvc_wide_t'(raw_reg)
                      * pvc_pkg::pvc_wide_t'(scale_high - scale_low);

    always_comb
    begin
        unique case (typ_reg)
            pvc_pkg::PVC_IN_VOLT:
                stage1_c = scale_low + scale_prod[pvc_pkg::FRAC_SH +: pvc_pkg::VW];
            pvc_pkg::PVC_IN_TC:
                // a junction error compensates with zero rather than a bad reading
                stage1_c = (junction_comp_select && !jerr_reg)
                         ? raw_reg + junction_temp : raw_reg;
            default:
                stage1_c = raw_reg;
        endcase
    end

    // ----------------------------------------
    // burn-out substitution
    // ----------------------------------------
    always_comb
    begin
        burn_c = filt_reg;
        if (typ_reg != pvc_pkg::PVC_IN_VOLT && burnout_select != pvc_pkg::PVC_BO_OFF
            && brk_reg)
            burn_c = (burnout_select == pvc_pkg::PVC_BO_UP) ? hi_lim : lo_lim;
    end

    // ----------------------------------------
    // piecewise segment select
    // ----------------------------------------
    always_comb
    begin
        if (burn_reg < bias_breakpoint_1)
        begin
            seg_s  = range_low;
            seg_e  = bias_breakpoint_1;
            seg_b0 = bias_at_low;
            seg_b1 = bias_at_point_1;
        end
        else if (burn_reg < bias_breakpoint_2)
        begin
            seg_s  = bias_breakpoint_1;
            seg_e  = bias_breakpoint_2;
            seg_b0 = bias_at_point_1;
            seg_b1 = bias_at_point_2;
        end
        else if (burn_reg < bias_breakpoint_3)
        begin
            seg_s  = bias_breakpoint_2;
            seg_e  = bias_breakpoint_3;
            seg_b0 = bias_at_point_2;
            seg_b1 = bias_at_point_3;
        end
        else
        begin
            seg_s  = bias_breakpoint_3;
            seg_e  = range_high;
            seg_b0 = bias_at_point_3;
            seg_b1 = bias_at_high;
        end
    end

    assign base_c = burn_reg + seg_b0 + global_bias;

    // ----------------------------------------
    // shared divider
    // ----------------------------------------
    always_comb
    begin
        div_need = 1'b0;
        div_num  = '0;
        div_den  = pvc_pkg::VAL_ZERO;
        unique case (state)
            S_FILT:
            begin
                // lag step (x - y) / (n + 1); residues below n + 1 never settle
                div_need = fprim_reg && input_filter_time != pvc_pkg::FILT_OFF;
                div_num  = pvc_pkg::pvc_wide_t'(stage1_reg - filt_reg);
                div_den  = pvc_pkg::pvc_val_t'({1'b0, input_filter_time}) + 24'sh000001;
            end
            S_BIAS:
            begin
                div_need = seg_e != seg_s;
                div_num  = pvc_pkg::pvc_wide_t'(burn_reg - seg_s)
                         * pvc_pkg::pvc_wide_t'(seg_b1 - seg_b0);
                div_den  = seg_e - seg_s;
            end
            S_DISP:
            begin
                div_need = dprim_reg && display_filter_time != pvc_pkg::FILT_OFF;
                div_num  = pvc_pkg::pvc_wide_t'(lim_reg - disp_reg);
                div_den  = pvc_pkg::pvc_val_t'({1'b0, display_filter_time}) + 24'sh000001;
            end
            default:
            begin
                div_need = 1'b0;
            end
        endcase
    end

    assign div_start = div_need && !wait_reg;

    pvc_div u_div (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .start    (div_start),
        .dividend (div_num),
        .divisor  (div_den),
        .done     (div_done),
        .quotient (div_q)
    );

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            wait_reg <= 1'b0;
        else if (div_done)
            wait_reg <= 1'b0;
        else if (div_start)
            wait_reg <= 1'b1;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state      <= S_IDLE;
            raw_reg    <= pvc_pkg::VAL_ZERO;
            typ_reg    <= pvc_pkg::PVC_IN_TC;
            brk_reg    <= 1'b0;
            jerr_reg   <= 1'b0;
            stage1_reg <= pvc_pkg::VAL_ZERO;
            filt_reg   <= pvc_pkg::VAL_ZERO;
            burn_reg   <= pvc_pkg::VAL_ZERO;
            corr_reg   <= pvc_pkg::VAL_ZERO;
            lim_reg    <= pvc_pkg::VAL_ZERO;
            disp_reg   <= pvc_pkg::VAL_ZERO;
            over_reg   <= 1'b0;
            under_reg  <= 1'b0;
            preset_reg <= 1'b0;
            fprim_reg  <= 1'b0;
            dprim_reg  <= 1'b0;
        end
        else
        begin
            unique case (state)
                S_IDLE:
                    if (sample_valid)
                    begin
                        raw_reg  <= raw_value;
                        typ_reg  <= input_type;
                        brk_reg  <= sensor_break;
                        jerr_reg <= junction_error;
                        state    <= S_SCALE;
                    end
                S_SCALE:
                begin
                    stage1_reg <= stage1_c;
                    state      <= S_FILT;
                end
                S_FILT:
                    if (!div_need)
                    begin
                        filt_reg  <= stage1_reg;
                        fprim_reg <= 1'b1;
                        state     <= S_BURN;
                    end
                    else if (div_done)
                    begin
                        filt_reg <= filt_reg + div_q[pvc_pkg::VW-1:0];
                        state    <= S_BURN;
                    end
                S_BURN:
                begin
                    burn_reg   <= burn_c;
                    preset_reg <= burn_c != filt_reg || (brk_reg
                                  && typ_reg != pvc_pkg::PVC_IN_VOLT
                                  && burnout_select != pvc_pkg::PVC_BO_OFF);
                    state      <= S_BIAS;
                end
                S_BIAS:
                    if (!div_need)
                    begin
                        corr_reg <= base_c;
                        state    <= S_LIMIT;
                    end
                    else if (div_done)
                    begin
                        corr_reg <= base_c + div_q[pvc_pkg::VW-1:0];
                        state    <= S_LIMIT;
                    end
                S_LIMIT:
                begin
                    over_reg  <= corr_reg > hi_lim;
                    under_reg <= corr_reg < lo_lim;
                    if (corr_reg > hi_lim)
                        lim_reg <= hi_lim;
                    else if (corr_reg < lo_lim)
                        lim_reg <= lo_lim;
                    else
                        lim_reg <= corr_reg;
                    state <= S_DISP;
                end
                S_DISP:
                    if (!div_need)
                    begin
                        disp_reg  <= lim_reg;
                        dprim_reg <= 1'b1;
                        state     <= S_OUT;
                    end
                    else if (div_done)
                    begin
                        disp_reg <= disp_reg + div_q[pvc_pkg::VW-1:0];
                        state    <= S_OUT;
                    end
                S_OUT:
                    state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // result outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pv_valid         <= 1'b0;
            pv_control       <= pvc_pkg::VAL_ZERO;
            pv_display       <= pvc_pkg::VAL_ZERO;
            over_range_flag  <= 1'b0;
            under_range_flag <= 1'b0;
            preset_request   <= 1'b0;
        end
        else
        begin
            pv_valid <= state == S_OUT;
            if (state == S_OUT)
            begin
                pv_control       <= lim_reg;
                pv_display       <= disp_reg;
                over_range_flag  <= over_reg;
                under_range_flag <= under_reg;
                preset_request   <= preset_reg;
            end
        end
    end

    // ----------------------------------------
    // setting management
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            typ_prev_reg           <= pvc_pkg::PVC_IN_TC;
            settings_reinit        <= 1'b0;
            scale_settings_visible <= 1'b0;
        end
        else
        begin
            typ_prev_reg           <= input_type;
            settings_reinit        <= input_type != typ_prev_reg;
            scale_settings_visible <= input_type == pvc_pkg::PVC_IN_VOLT;
        end
    end

    // ----------------------------------------
    // junction error display alternation
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            alt_cnt_reg          <= '0;
            alt_phase_reg        <= 1'b0;
            junction_alarm_phase <= 1'b0;
        end
        else
        begin
            if (!junction_error)
            begin
                alt_cnt_reg   <= '0;
                alt_phase_reg <= 1'b0;
            end
            else if (alt_cnt_reg == pvc_pkg::ALT_W'(ALT_CYCLES - 1))
            begin
                alt_cnt_reg   <= '0;
                alt_phase_reg <= !alt_phase_reg;
            end
            else
                alt_cnt_reg <= alt_cnt_reg + 1'b1;
            junction_alarm_phase <= junction_error && !alt_phase_reg;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_take;
        state == S_IDLE && sample_valid;
    endsequence

    sequence s_done;
        ##[1:200] pv_valid;
    endsequence

    a_order_latency: assert property (s_take |-> s_done)
        else $error("sample not finished in time");
    a_clamp_high: assert property (pv_valid |-> pv_control <= hi_lim)
        else $error("control value above high limit");
    a_clamp_low: assert property (pv_valid |-> pv_control >= lo_lim)
        else $error("control value below low limit");
    a_flag_over: assert property (pv_valid && over_range_flag |-> pv_control == hi_lim)
        else $error("over flag without clamp");
    a_volt_no_detect: assert property (state == S_BURN && typ_reg == pvc_pkg::PVC_IN_VOLT
        |=> burn_reg == filt_reg && !preset_reg)
        else $error("burn-out acted on voltage input");
    a_bo_off_quiet: assert property (state == S_BURN
        && burnout_select == pvc_pkg::PVC_BO_OFF |=> !preset_reg)
        else $error("preset requested with burn-out off");
    a_disp_off: assert property (pv_valid && display_filter_time == pvc_pkg::FILT_OFF
        |-> pv_display == pv_control)
        else $error("display filter off but value differs");
    a_junc_zero: assert property (state == S_FILT && $past(state) == S_SCALE
        && typ_reg == pvc_pkg::PVC_IN_TC && jerr_reg |-> stage1_reg == raw_reg)
        else $error("junction error not compensated with zero");
    a_reinit_pulse: assert property (input_type != $past(input_type)
        |=> settings_reinit)
        else $error("type change without reinit pulse");
    a_filt_pass: assert property (state == S_BURN
        && input_filter_time == pvc_pkg::FILT_OFF |-> filt_reg == stage1_reg)
        else $error("input filter off but not pass-through");
endmodule : pvc_top
`default_nettype wire

// file: tb/pvc_sensor_model.sv
// sensor front end model: offers one sample per call
// assumes the block is idle whenever offer is called
`timescale 1ns/1ps
`default_nettype none
module pvc_sensor_model (
    // clock
    input  wire logic        clk_sys,
    // sample lines
    output logic              sample_valid,
    output pvc_pkg::pvc_val_t raw_value,
    output logic              sensor_break,
    output pvc_pkg::pvc_val_t junction_temp,
    output logic              junction_error
);
    initial
    begin
        sample_valid = 1'b0;
        raw_value = 24'sh000000;
        sensor_break = 1'b0;
        junction_temp = 24'sh000019;
        junction_error = 1'b0;
    end
    // value is not held after the pulse, so its inverse shows afterwards
    task automatic offer(input pvc_pkg::pvc_val_t v, input logic b);
        @(posedge clk_sys);
        #1;
        raw_value = v;
        sensor_break = b;
        sample_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        sample_valid = 1'b0;
        raw_value = ~v;
    endtask : offer
endmodule : pvc_sensor_model
`default_nettype wire

// file: tb/tb_top.sv
// conditioning testbench: span 0..1000, breakpoints 250/500/750
// assumes filters off unless a test sets them
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, arst_n, sample_valid, sensor_break, junction_error, pv_valid;
    logic over_range_flag, under_range_flag, preset_request, junction_alarm_phase;
    logic scale_settings_visible, settings_reinit, junction_comp_select = 1'b1;
    logic [6:0] input_filter_time = 7'h00, display_filter_time = 7'h00;
    pvc_pkg::pvc_in_t input_type = pvc_pkg::PVC_IN_TC;
    pvc_pkg::pvc_bo_t burnout_select = pvc_pkg::PVC_BO_UP;
    pvc_pkg::pvc_val_t raw_value, junction_temp, pv_control, pv_display;
    pvc_pkg::pvc_val_t range_high = 24'sh0003e8, range_low = 24'sh000000;
    pvc_pkg::pvc_val_t scale_high = 24'sh0000c8, scale_low = 24'sh000000;
    pvc_pkg::pvc_val_t global_bias = 24'sh000000, bias_breakpoint_1 = 24'sh0000fa;
    pvc_pkg::pvc_val_t bias_breakpoint_2 = 24'sh0001f4, bias_breakpoint_3 = 24'sh0002ee;
    pvc_pkg::pvc_val_t bias_at_low = 24'sh000000, bias_at_point_1 = 24'sh000000;
    pvc_pkg::pvc_val_t bias_at_point_2 = 24'sh000000, bias_at_point_3 = 24'sh000000;
    pvc_pkg::pvc_val_t bias_at_high = 24'sh000000;
    localparam int ALT = 8;
    int fails = 0, cmp_count = 0;

    pvc_sensor_model u_sensor (.clk_sys, .sample_valid, .raw_value, .sensor_break,
        .junction_temp, .junction_error);
    pvc_top #(.ALT_CYCLES(ALT)) u_dut (.clk_sys, .arst_n, .sample_valid, .raw_value,
        .sensor_break, .junction_temp, .junction_error, .input_type, .range_high,
        .range_low, .scale_high, .scale_low, .input_filter_time, .display_filter_time,
        .burnout_select, .junction_comp_select, .global_bias, .bias_breakpoint_1,
        .bias_breakpoint_2, .bias_breakpoint_3, .bias_at_low, .bias_at_point_1,
        .bias_at_point_2, .bias_at_point_3, .bias_at_high, .pv_valid, .pv_control,
        .pv_display, .over_range_flag, .under_range_flag, .preset_request,
        .scale_settings_visible, .settings_reinit, .junction_alarm_phase);

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [23:0] s, x);
        cmp_count++;
        if (s !== x)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    // one sample; d is the displayed value, f is {over, under, preset}
    task automatic smp(input string nm, input pvc_pkg::pvc_val_t v, e, d,
        input logic b, input logic [2:0] f);
        int n;
        u_sensor.offer(v, b);
        n = 0;
        while (pv_valid !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("pv_valid", pv_valid, 1'b1);
        chk("pv_control", pv_control, e);
        chk("pv_display", pv_display, d);
        chk("flags", {over_range_flag, under_range_flag, preset_request}, f);
        $display("test %s done", nm);
    endtask : smp

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    initial
    begin
        #50000;
        fails++;
        end_sim();
    end

    initial
    begin
        int seen;
        arst_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        chk("hidden", scale_settings_visible, 1'b0);
        chk("no reinit", settings_reinit, 1'b0);
        smp("comp on", 24'sh000064, 24'sh00007d, 24'sh00007d, 1'b0, 3'h0);
        junction_comp_select = 1'b0;
        smp("comp off", 24'sh000064, 24'sh000064, 24'sh000064, 1'b0, 3'h0);
        junction_comp_select = 1'b1;
        u_sensor.junction_error = 1'b1;
        smp("junc err", 24'sh000064, 24'sh000064, 24'sh000064, 1'b0, 3'h0);
        // steady alternation: any window of two half periods is half high
        seen = 0;
        repeat (2 * ALT)
        begin
            @(posedge clk_sys);
            #1;
            seen += junction_alarm_phase;
        end
        chk("alarm phase", seen, 24'(ALT));
        u_sensor.junction_error = 1'b0;
        @(posedge clk_sys);
        #1;
        chk("alarm off", junction_alarm_phase, 1'b0);
        junction_comp_select = 1'b0;
        global_bias = 24'sh00000a;
        smp("bias", 24'sh000064, 24'sh00006e, 24'sh00006e, 1'b0, 3'h0);
        global_bias = 24'sh000000;
        bias_at_point_1 = 24'sh000064;
        smp("piecewise", 24'sh00007d, 24'sh0000af, 24'sh0000af, 1'b0, 3'h0);
        bias_at_point_1 = 24'sh000000;
        smp("over", 24'sh0007d0, 24'sh00041a, 24'sh00041a, 1'b0, 3'h4);
        smp("under", 24'shffff38, 24'shffffce, 24'shffffce, 1'b0, 3'h2);
        smp("bo up", 24'sh000064, 24'sh00041a, 24'sh00041a, 1'b1, 3'h1);
        burnout_select = pvc_pkg::PVC_BO_DOWN;
        smp("bo down", 24'sh000064, 24'shffffce, 24'shffffce, 1'b1, 3'h1);
        burnout_select = pvc_pkg::PVC_BO_OFF;
        smp("bo off", 24'sh000064, 24'sh000064, 24'sh000064, 1'b1, 3'h0);
        burnout_select = pvc_pkg::PVC_BO_UP;
        input_type = pvc_pkg::PVC_IN_VOLT;
        @(posedge clk_sys);
        #1;
        chk("reinit", settings_reinit, 1'b1);
        chk("visible", scale_settings_visible, 1'b1);
        @(posedge clk_sys);
        #1;
        chk("reinit end", settings_reinit, 1'b0);
        smp("volt", 24'sh008000, 24'sh000064, 24'sh000064, 1'b1, 3'h0);
        input_type = pvc_pkg::PVC_IN_TC;
        display_filter_time = 7'h01;
        smp("dfl", 24'sh00012c, 24'sh00012c, 24'sh0000c8, 1'b0, 3'h0);
        input_filter_time = 7'h01;
        smp("ifl", 24'sh000064, 24'sh0000c8, 24'sh0000c8, 1'b0, 3'h0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
